// [hdl/shreg_pkg.sv]
// constants of the four-stage shift register; its input filter reads none of them
// assumes one 10 MHz system clock and an active-low asynchronous reset
`default_nettype none
package shreg_pkg;
   localparam int unsigned      STAGE_COUNT   = 4;     // storage stages
   localparam int unsigned      SYNC_DEPTH    = 3;     // flip-flops per pin input
   localparam int unsigned      CLOCK_PERIOD_NS = 100; // system clock period
   // bit positions inside the filtered pin vector
   localparam int unsigned      PIN_PAR_LSB   = 0;     // parallel data 0..3
   localparam int unsigned      PIN_SERIAL    = 4;
   localparam int unsigned      PIN_MODE      = 5;
   localparam int unsigned      PIN_DRIVE     = 6;
   localparam int unsigned      PIN_DEV_CLK   = 7;
   localparam int unsigned      PIN_COUNT     = 8;
   // reset values
   localparam logic [3:0]       STAGE_RST     = 4'h0;
   localparam logic [3:0]       KNOWN_RST     = 4'h0;
   localparam logic [7:0]       PIN_RST       = 8'h00;
   localparam logic             DRIVE_RST     = 1'b0;
endpackage
`default_nettype wire

// [hdl/pin_filter.sv]
// three-flop input filter for pins from outside the clock domain
// assumes every bit is asynchronous to clk_i; output changes once stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none
module pin_filter #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } filt_state_t;

   filt_state_t q;
   filt_state_t d;

   // refuse a width the logic cannot serve
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_filter: WIDTH must be at least 1");
   end

   // s1 feeds only s2; the filtered level follows s3 where s2 agrees
   always_comb begin
      d    = q;
      d.s1 = pin_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.filt[i] = q.s3[i];
         end
      end
   end

   // state register, constant reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level_o = q.filt;
endmodule
`default_nettype wire

// [hdl/shift_register4.sv]
// four-stage load / shift-right register with three-state stage outputs
// assumes all inputs are board pins, asynchronous to CLOCK_I; the device clock
// arrives on DEV_CLK_I and its falling edge is found by sampling
//
// What this block does
// - four stages, four data, serial, mode, drive
// - stages change only on device clock fall
// - mode high: stages take parallel inputs
// - serial input ignored during parallel load
// - mode low: shift right, serial into stage0
// - drive high: outputs driven with stage contents
// - drive low: all four stage outputs high impedance
// - disabled outputs never stop register operation
`timescale 1ns/10ps
`default_nettype none
module shift_register4 (
   input  wire logic       CLOCK_I,
   input  wire logic       RST_B_I,
   input  wire logic       DEV_CLK_I,
   input  wire logic [3:0] PAR_DATA_I,
   input  wire logic       SHIFT_ENTRY_BIT_I,
   input  wire logic       MODE_SELECT_LINE_I,
   input  wire logic       OUTPUT_DRIVE_ENABLE_I,
   output logic            STAGE0_OUT_O,
   output logic            STAGE0_OUT_OE_O,
   output logic            STAGE1_OUT_O,
   output logic            STAGE1_OUT_OE_O,
   output logic            STAGE2_OUT_O,
   output logic            STAGE2_OUT_OE_O,
   output logic            STAGE3_OUT_O,
   output logic            STAGE3_OUT_OE_O,
   output logic            CONTENT_KNOWN_O
);
   // path of every pin through this block, in system clock edges:
   //   edge 1  the pin level enters the first filter flop
   //   edge 4  the filtered level moves once filter flops two and three agree
   //   edge 5  stages, output enables and the known flag take new values
   // all pins share the filter, so data, mode and serial bit reach the
   // decode logic in the same cycle as the filtered device clock fall;
   // no pin can be taken a cycle ahead of the clock it belongs to
   //
   // limitations a user must know:
   //   the device clock must stay high and low for at least two system
   //   clocks each, or the filter may never see a settled level
   //   data and mode must stand from one cycle before the fall to two
   //   cycles after it, since they are seen through the same filter
   //   the output disable is seen five system clocks late, not at once,
   //   because every output must come from a flop
   //   stages read zero after reset; the known flag tells when the
   //   contents are real data and not just the reset pattern
   //
   // left shift needs no logic here: the board feeds stage outputs 1..3
   // back to parallel pins 0..2 and the new bit to parallel pin 3, and
   // holds the mode pin high, so each fall runs an ordinary load; the
   // fed-back levels change only after the load that used them, so the
   // loop adds nothing to the five edge latency

   // short local names for the package positions used below
   localparam int unsigned NSTAGE   = shreg_pkg::STAGE_COUNT;
   localparam int unsigned NPIN     = shreg_pkg::PIN_COUNT;
   localparam int unsigned PAR_LSB  = shreg_pkg::PIN_PAR_LSB;
   localparam int unsigned SER_BIT  = shreg_pkg::PIN_SERIAL;
   localparam int unsigned MODE_BIT = shreg_pkg::PIN_MODE;
   localparam int unsigned DRV_BIT  = shreg_pkg::PIN_DRIVE;
   localparam int unsigned DCLK_BIT = shreg_pkg::PIN_DEV_CLK;

   // refuse package values that the fixed port list cannot serve
   if (NSTAGE != 4) begin : g_bad_stages
      $error("shift_register4: four stages are wired to the ports");
   end
   if (NPIN != NSTAGE + 4) begin : g_bad_pins
      $error("shift_register4: pin vector must hold data plus four controls");
   end
   if (PAR_LSB + NSTAGE > SER_BIT) begin : g_bad_par
      $error("shift_register4: parallel pins overlap the serial pin");
   end
   if (DCLK_BIT >= NPIN || DRV_BIT >= NPIN || MODE_BIT >= NPIN) begin : g_bad_ctl
      $error("shift_register4: control pin outside the pin vector");
   end
   if (shreg_pkg::SYNC_DEPTH != 3) begin : g_bad_sync
      $error("shift_register4: the pin filter has exactly three flops");
   end

   // whole state of the block, registered as one word
   typedef struct packed {
      logic       clk_prev;  // filtered device clock, one cycle old
      logic [3:0] stage;     // storage stages 0..3
      logic [3:0] known;     // stages holding defined data
      logic       known_all; // all four stages defined, for the output flop
      logic       drive;     // registered output enable
   } reg_state_t;

   reg_state_t       q;
   reg_state_t       d;
   logic [NPIN-1:0]  pins;        // raw pins, gathered for the filter
   logic [NPIN-1:0]  level;       // filtered pins
   logic             dev_clk;     // filtered device clock
   logic             fall;        // device clock fell in this cycle
   logic             load_mode;   // filtered mode pin, high selects load
   logic             serial_bit;  // filtered serial entry pin
   logic             drive_pin;   // filtered output control pin
   logic [3:0]       par_level;   // filtered parallel data pins
   logic             load_now;    // a load happens in this cycle
   logic             shift_now;   // a right shift happens in this cycle
   wire  logic [3:0] stage_load;  // stage values a load would give
   wire  logic [3:0] stage_shift; // stage values a shift would give
   wire  logic [3:0] known_shift; // known flags a shift would give

   // gather pins into one vector for the filter
   assign pins = {DEV_CLK_I, OUTPUT_DRIVE_ENABLE_I, MODE_SELECT_LINE_I,
                  SHIFT_ENTRY_BIT_I, PAR_DATA_I};

   pin_filter #(
      .WIDTH (NPIN)
   ) u_filter (
      .clk_i   (CLOCK_I),
      .rst_b_i (RST_B_I),
      .pin_i   (pins),
      .level_o (level)
   );

   // split the filtered vector into named levels
   assign dev_clk    = level[DCLK_BIT];
   assign load_mode  = level[MODE_BIT];
   assign serial_bit = level[SER_BIT];
   assign drive_pin  = level[DRV_BIT];
   assign par_level  = level[PAR_LSB +: 4];

   // a fall is a filtered high followed by a filtered low; the edge
   // register resets low like the filter, so the idle-high pin coming
   // out of reset shows as a rise and never as a false fall
   assign fall = q.clk_prev & ~dev_clk;

   // the mode level picks the operation only at a fall
   assign load_now  = fall & load_mode;
   assign shift_now = fall & ~load_mode;

   // per-stage candidates for a load and for a right shift
   for (genvar k = 0; k < 4; k++) begin : g_stage
      // a load takes the matching parallel pin, never the serial one
      assign stage_load[k] = par_level[k];
      if (k == 0) begin : g_entry
         // stage 0 takes the serial entry bit and is known from then on
         assign stage_shift[k] = serial_bit;
         assign known_shift[k] = 1'h1;
      end else begin : g_chain
         // later stages take the old value of the stage before them
         assign stage_shift[k] = q.stage[k-1];
         assign known_shift[k] = q.known[k-1];
      end
   end

   // next state: load or shift on a device clock fall, else hold
   always_comb begin
      d          = q;
      d.clk_prev = dev_clk;
      d.drive    = drive_pin;
      // loads and shifts never look at the drive level
      case ({load_now, shift_now})
         2'h2: begin
            d.stage = stage_load;
            d.known = 4'hF;
         end
         2'h1: begin
            d.stage = stage_shift;
            d.known = known_shift;
         end
         default: begin
            d.stage = q.stage;
            d.known = q.known;
         end
      endcase
      // summary flag is registered so the output comes from a flop
      d.known_all = &d.known;
   end

   // state register, constant reset
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         q.clk_prev  <= 1'h0;
         q.stage     <= shreg_pkg::STAGE_RST;
         q.known     <= shreg_pkg::KNOWN_RST;
         q.known_all <= &shreg_pkg::KNOWN_RST;
         q.drive     <= shreg_pkg::DRIVE_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state flops; data keeps running when undriven
   assign STAGE0_OUT_O    = q.stage[0];
   assign STAGE1_OUT_O    = q.stage[1];
   assign STAGE2_OUT_O    = q.stage[2];
   assign STAGE3_OUT_O    = q.stage[3];
   // one enable flop for all four pins, so they switch together
   assign STAGE0_OUT_OE_O = q.drive;
   assign STAGE1_OUT_OE_O = q.drive;
   assign STAGE2_OUT_OE_O = q.drive;
   assign STAGE3_OUT_OE_O = q.drive;
   assign CONTENT_KNOWN_O = q.known_all;
endmodule
`default_nettype wire

// [verif/shreg_properties.sv]
// checker on the register's top ports
// assumes pins steady around each device clock fall
`timescale 1ns/10ps
`default_nettype none
module shreg_chk (
   input  wire logic       CLOCK_I,
   input  wire logic       RST_B_I,
   input  wire logic       DEV_CLK_I,
   input  wire logic [3:0] PAR_DATA_I,
   input  wire logic       SHIFT_ENTRY_BIT_I,
   input  wire logic       MODE_SELECT_LINE_I,
   input  wire logic       OUTPUT_DRIVE_ENABLE_I,
   input  wire logic       STAGE0_OUT_O,
   input  wire logic       STAGE0_OUT_OE_O,
   input  wire logic       STAGE1_OUT_O,
   input  wire logic       STAGE1_OUT_OE_O,
   input  wire logic       STAGE2_OUT_O,
   input  wire logic       STAGE2_OUT_OE_O,
   input  wire logic       STAGE3_OUT_O,
   input  wire logic       STAGE3_OUT_OE_O,
   input  wire logic       CONTENT_KNOWN_O
);
   wire logic [3:0] stg = {STAGE3_OUT_O, STAGE2_OUT_O, STAGE1_OUT_O, STAGE0_OUT_O};
   wire logic [3:0] oe = {STAGE3_OUT_OE_O, STAGE2_OUT_OE_O, STAGE1_OUT_OE_O, STAGE0_OUT_OE_O};
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   // device clock falls in load and shift mode
   sequence load_s; $fell(DEV_CLK_I) && MODE_SELECT_LINE_I; endsequence
   sequence shift_s; $fell(DEV_CLK_I) && !MODE_SELECT_LINE_I; endsequence
   chk_load_take: assert property (load_s |-> ##5 stg == $past(PAR_DATA_I, 5))
      else $error("load");
   chk_shift_right: assert property (shift_s |-> ##5 stg == {$past(stg[2:0]), $past(SHIFT_ENTRY_BIT_I, 5)})
      else $error("shift");
   chk_known_load: assert property (load_s |-> ##5 CONTENT_KNOWN_O)
      else $error("known");
   chk_known_keep: assert property (CONTENT_KNOWN_O |=> CONTENT_KNOWN_O)
      else $error("known lost");
   chk_stage_hold: assert property ($stable(DEV_CLK_I) [*7] |-> $stable(stg))
      else $error("hold");
   chk_drive_on: assert property (OUTPUT_DRIVE_ENABLE_I [*6] |=> oe == 4'hf)
      else $error("drive on");
   chk_drive_off: assert property (!OUTPUT_DRIVE_ENABLE_I [*6] |=> oe == 4'h0)
      else $error("drive off");
   chk_oe_equal: assert property (oe == 4'h0 || oe == 4'hf)
      else $error("oe split");
endmodule
bind shift_register4 shreg_chk u_chk (
   .CLOCK_I               (CLOCK_I),
   .RST_B_I               (RST_B_I),
   .DEV_CLK_I             (DEV_CLK_I),
   .PAR_DATA_I            (PAR_DATA_I),
   .SHIFT_ENTRY_BIT_I     (SHIFT_ENTRY_BIT_I),
   .MODE_SELECT_LINE_I    (MODE_SELECT_LINE_I),
   .OUTPUT_DRIVE_ENABLE_I (OUTPUT_DRIVE_ENABLE_I),
   .STAGE0_OUT_O          (STAGE0_OUT_O),
   .STAGE0_OUT_OE_O       (STAGE0_OUT_OE_O),
   .STAGE1_OUT_O          (STAGE1_OUT_O),
   .STAGE1_OUT_OE_O       (STAGE1_OUT_OE_O),
   .STAGE2_OUT_O          (STAGE2_OUT_O),
   .STAGE2_OUT_OE_O       (STAGE2_OUT_OE_O),
   .STAGE3_OUT_O          (STAGE3_OUT_O),
   .STAGE3_OUT_OE_O       (STAGE3_OUT_OE_O),
   .CONTENT_KNOWN_O       (CONTENT_KNOWN_O)
);
`default_nettype wire

// [verif/board_link.sv]
// board wiring: straight data or left-shift loopback
// assumes stage pins pulled high while undriven
`timescale 1ns/10ps
`default_nettype none
module board_link (
   input  wire logic       loop_i,
   input  wire logic       ser_i,
   input  wire logic [3:0] data_i,
   input  wire logic [3:0] q_i,
   input  wire logic [3:0] oe_i,
   output logic      [3:0] par_o
);
   wire logic [3:0] pin = q_i | ~oe_i; // pull-up on undriven pin
   // outputs 1..3 back to inputs 0..2, serial on input 3
   assign par_o = loop_i ? {ser_i, pin[3:1]} : data_i;
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the four-stage register
// assumes board wiring from board_link
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, dclk = 1'b1, mode = 1'b1, shift_entry_bit = 1'b0, oen = 1'b1, loop = 1'b0;
   logic [3:0] data = 4'h0, e = 4'h0;
   int n_errors = 0, compares = 0;
   wire logic [3:0] par, q, oe;
   wire logic known;
   initial forever #50 clk = ~clk;
   shift_register4 dut (.CLOCK_I(clk), .RST_B_I(rst_b), .DEV_CLK_I(dclk), .PAR_DATA_I(par),
      .SHIFT_ENTRY_BIT_I(shift_entry_bit), .MODE_SELECT_LINE_I(mode), .OUTPUT_DRIVE_ENABLE_I(oen),
      .STAGE0_OUT_O(q[0]), .STAGE0_OUT_OE_O(oe[0]), .STAGE1_OUT_O(q[1]), .STAGE1_OUT_OE_O(oe[1]),
      .STAGE2_OUT_O(q[2]), .STAGE2_OUT_OE_O(oe[2]), .STAGE3_OUT_O(q[3]), .STAGE3_OUT_OE_O(oe[3]),
      .CONTENT_KNOWN_O(known));
   board_link link (.loop_i(loop), .ser_i(shift_entry_bit), .data_i(data), .q_i(q), .oe_i(oe), .par_o(par));
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one device clock fall; expected stages follow mode and wiring
   task automatic fall(input logic m, input logic [3:0] d, input logic s);
      mode <= m;
      data <= d;
      shift_entry_bit <= s;
      repeat (2) @(posedge clk);
      dclk <= 1'b0;
      repeat (6) @(posedge clk);
      dclk <= 1'b1;
      repeat (4) @(posedge clk);
      e = m ? (loop ? {s, e[3:1]} : d) : {e[2:0], s};
      chk(q, e);
   endtask
   task automatic t_drive;
      // serial high while data bit 0 is low, so a leaking serial bit shows
      fall(1'b1, 4'ha, 1'b1);
      chk(oe, 4'hf);
      oen <= 1'b0;
      repeat (7) @(posedge clk);
      chk(oe, 4'h0);
      // serial low while data bit 0 is high
      fall(1'b1, 4'h5, 1'b0);
      fall(1'b0, 4'h0, 1'b1);
      oen <= 1'b1;
      repeat (7) @(posedge clk);
      chk(oe, 4'hf);
      $display("drive done");
   endtask
   task automatic t_left;
      loop <= 1'b1;
      fall(1'b1, 4'h0, 1'b1);
      fall(1'b1, 4'hf, 1'b0);
      loop <= 1'b0;
      $display("left done");
   endtask
   task automatic t_known;
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      e = 4'h0;
      repeat (5) @(posedge clk);
      repeat (3) fall(1'b0, 4'hf, 1'b1);
      chk({3'h0, known}, 4'h0);
      fall(1'b0, 4'h0, 1'b0);
      chk({3'h0, known}, 4'h1);
      $display("known done");
   endtask
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      t_drive;
      t_left;
      t_known;
      stop_test;
   end
   // watchdog well past the planned run
   initial begin
      repeat (2000) @(posedge clk);
      n_errors++;
      stop_test;
   end
endmodule
`default_nettype wire
